// ---- shared/ppp_pkg.sv ----
// Constants, types and decode functions for the programmable parallel port
//
// What this block does
// - Three modes: basic, strobed, bidirectional
// - Basic: ports A, B, two C nibbles
// - Basic: outputs latched, inputs read live
// - Basic: no handshake on transfers
// - Bit 7 set means mode definition
// - Bits 4,3,1,0 set input directions
// - Strobed: group A and group B
// - Strobed data ports latched both directions
// - Port C lines carry handshake signals
// - Bidirectional mode on group A only
// - Single control word sets/clears C bit
// - Strobed A input: C bits 6,7 general
// - Strobed B: no spare C lines
// - Port C read gives status word
// - Input-full rises on the same edge that captures data
// - Enables written via C bit 4, 6, 2
// - Input request equals enable and input-full; output request is enable and buffer empty
// - Status word omits strobe levels
// - Offsets 0..3: A, B, C, control
package ppp_pkg;

  // Register offsets on the host port
  localparam logic [1:0] ADDR_PORT_A = 2'h0;
  localparam logic [1:0] ADDR_PORT_B = 2'h1;
  localparam logic [1:0] ADDR_PORT_C = 2'h2;
  localparam logic [1:0] ADDR_CTRL   = 2'h3;

  // Control word fields
  localparam int CW_MODE_SET  = 7;  // Mode definition flag
  localparam int CW_A_MODE_HI = 6;  // Group A bidirectional select
  localparam int CW_A_MODE_LO = 5;  // Group A strobed select
  localparam int CW_A_IN      = 4;  // Port A direction
  localparam int CW_CU_IN     = 3;  // Upper C nibble direction
  localparam int CW_B_MODE    = 2;  // Group B strobed select
  localparam int CW_B_IN      = 1;  // Port B direction
  localparam int CW_CL_IN     = 0;  // Lower C nibble direction
  localparam int SR_SEL_HI    = 3;  // Bit set/reset select, top
  localparam int SR_SEL_LO    = 1;  // Bit set/reset select, bottom
  localparam int SR_VAL       = 0;  // Bit set/reset value

  // Port C line roles under handshake
  localparam int PC_INTR_B    = 0;
  localparam int PC_FULL_B    = 1;
  localparam int PC_STB_B     = 2;
  localparam int PC_INTR_A    = 3;
  localparam int PC_STB_A     = 4;
  localparam int PC_FULL_A    = 5;
  localparam int PC_ACK_A     = 6;
  localparam int PC_OBF_A     = 7;
  localparam int PC_NIB_SPLIT = 4;  // First bit of the upper nibble

  // Reset values: mode 0, every port an input
  localparam logic [7:0] CTRL_RST = 8'h9b;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Group A operating mode
  typedef enum logic [1:0] {AM_BASIC, AM_STROBED, AM_BIDIR} ppp_amode_t;

  // Group A mode from a control word
  function automatic ppp_amode_t ppp_a_mode(input logic [7:0] cw);
    if (cw[CW_A_MODE_HI]) begin
      return AM_BIDIR;
    end else if (cw[CW_A_MODE_LO]) begin
      return AM_STROBED;
    end
    return AM_BASIC;
  endfunction

  // Direction of a general port C line from a control word
  function automatic logic ppp_c_is_in(input logic [7:0] cw, input int bit_idx);
    return (bit_idx >= PC_NIB_SPLIT) ? cw[CW_CU_IN] : cw[CW_CL_IN];
  endfunction

endpackage

// ---- rtl/ppp_strobe_in.sv ----
// Strobed input latch with input-full flag for one data port
`timescale 1ns/1ps
module ppp_strobe_in (
  input  wire logic       clock_i,    // System clock
  input  wire logic       rst_n_i,    // Synchronous reset, active low
  input  wire logic       enable_i,   // Port is in a capturing mode
  input  wire logic       strobe_n_i, // Strobe pin level, active low
  input  wire logic [7:0] data_i,     // Data pin levels
  input  wire logic       clear_i,    // Host read or mode change
  output logic      [7:0] data_o,     // Captured byte
  output logic            full_o      // Input-full flag
);
  import ppp_pkg::*;

  typedef struct packed {
    logic       strobe_prev; // Strobe level last cycle
    logic [7:0] data;        // Input latch
    logic       full;        // Input-full
  } ppp_stb_state_t;

  ppp_stb_state_t cur_ff;   // Registered state
  ppp_stb_state_t nxt_cur;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.strobe_prev = strobe_n_i;
    if (clear_i) begin
      nxt_cur.full = 1'b0;
    end
    // Strobe falling latches
    // Capture wins over a clear in the same cycle, so no byte is lost
    if (enable_i && cur_ff.strobe_prev && !strobe_n_i) begin
      nxt_cur.data = data_i;
      nxt_cur.full = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_ff <= '{strobe_prev: 1'b1, data: BYTE_RST, full: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign data_o = cur_ff.data;
  assign full_o = cur_ff.full;

endmodule // ppp_strobe_in

// ---- rtl/ppp_portc_pins.sv ----
// Registered port C pin drivers: handshake lines over general lines
`timescale 1ns/1ps
module ppp_portc_pins (
  input  wire logic       clock_i,   // System clock
  input  wire logic       rst_n_i,   // Synchronous reset, active low
  input  wire logic [7:0] ctrl_i,    // Current control word
  input  wire logic [7:0] latch_i,   // Port C output latch
  input  wire logic [7:0] hs_own_i,  // Line driven by a handshake
  input  wire logic [7:0] hs_val_i,  // Handshake value to drive
  input  wire logic [7:0] hs_in_i,   // Line is a handshake input
  output logic      [7:0] pin_out_o, // Pin output levels
  output logic      [7:0] pin_oe_o   // Pin output enables
);
  import ppp_pkg::*;

  typedef struct packed {
    logic [7:0] out; // Pin output
    logic [7:0] oe;  // Pin enable
  } ppp_pc_state_t;

  ppp_pc_state_t cur_ff;   // Registered state
  ppp_pc_state_t nxt_cur;  // Next state
  logic [7:0]    bit_out;  // Per-line output value
  logic [7:0]    bit_oe;   // Per-line enable

  // Handshake line roles
  // Each line picks handshake, strobe or acknowledge input, or general nibble direction
  for (genvar gi = 0; gi < 8; gi++) begin : g_line
    assign bit_out[gi] = hs_own_i[gi] ? hs_val_i[gi] : latch_i[gi];
    assign bit_oe[gi]  = hs_own_i[gi] | (!hs_in_i[gi] & !ppp_c_is_in(ctrl_i, gi));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_cur.out = bit_out;
    nxt_cur.oe  = bit_oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves every line undriven
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_ff <= '{out: BYTE_RST, oe: BYTE_RST};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pin_out_o = cur_ff.out;
  assign pin_oe_o  = cur_ff.oe;

endmodule // ppp_portc_pins

// ---- rtl/ppp_top.sv ----
// Top of the programmable parallel port: host registers, ports A, B, C
`timescale 1ns/1ps
module ppp_top (
  input  wire logic       clock_i,      // System clock, 125 MHz
  input  wire logic       rst_n_i,      // Synchronous reset, active low
  input  wire logic [1:0] addr_i,       // Register offset
  input  wire logic       wr_en_i,      // Write strobe, one cycle
  input  wire logic       rd_en_i,      // Read strobe, one cycle
  input  wire logic [7:0] wdata_i,      // Write data
  output logic      [7:0] rdata_o,      // Read data, one cycle after read
  input  wire logic [7:0] port_a_in_i,  // Port A pin levels
  output logic      [7:0] port_a_out_o, // Port A drive value
  output logic      [7:0] port_a_oe_o,  // Port A drive enable
  input  wire logic [7:0] port_b_in_i,  // Port B pin levels
  output logic      [7:0] port_b_out_o, // Port B drive value
  output logic      [7:0] port_b_oe_o,  // Port B drive enable
  input  wire logic [7:0] port_c_in_i,  // Port C pin levels
  output logic      [7:0] port_c_out_o, // Port C drive value
  output logic      [7:0] port_c_oe_o   // Port C drive enable
);
  import ppp_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;             // Mode control word
    logic [7:0] a_lat;            // Port A output latch
    logic [7:0] b_lat;            // Port B output latch
    logic [7:0] c_lat;            // Port C output latch
    logic       irq_enable_a;     // Group A input enable
    logic       irq_enable_a_out; // Group A output enable
    logic       irq_enable_b;     // Group B enable
    logic       obf_n_a;          // Port A output buffer empty, high
    logic       obf_n_b;          // Port B output buffer empty, high
    logic [7:0] rdata;            // Read data register
    logic [7:0] a_oe;             // Port A enable register
    logic [7:0] b_oe;             // Port B enable register
  } ppp_top_state_t;

  ppp_top_state_t cur_ff;   // Registered state
  ppp_top_state_t nxt_cur;  // Next state

  ppp_amode_t amode;        // Group A mode
  logic       a_in;         // Port A direction bit
  logic       b_in;         // Port B direction bit
  logic       b_strobed;    // Group B in strobed mode
  logic       a_capture;    // Port A captures on strobe
  logic       a_out_hs;     // Port A has output handshake
  logic       b_capture;    // Port B captures on strobe
  logic       b_out_hs;     // Port B has output handshake
  logic       mode_wr;      // Mode definition written this cycle
  logic       rd_a;         // Host reads port A
  logic       rd_b;         // Host reads port B
  logic [7:0] cap_a;        // Captured port A byte
  logic [7:0] cap_b;        // Captured port B byte
  logic       input_full_a; // Port A input-full
  logic       input_full_b; // Port B input-full
  logic       irq_request_a;
  logic       irq_request_b;
  logic [7:0] hs_own;       // Handshake-driven C lines
  logic [7:0] hs_val;       // Handshake values
  logic [7:0] hs_in;        // Handshake input C lines
  logic [7:0] c_status;     // Port C read value
  logic [2:0] sr_sel;       // Bit set/reset target

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  // Mode selection
  assign amode     = ppp_a_mode(cur_ff.ctrl);
  assign a_in      = cur_ff.ctrl[CW_A_IN];
  assign b_in      = cur_ff.ctrl[CW_B_IN];
  assign b_strobed = cur_ff.ctrl[CW_B_MODE];
  assign a_capture = (amode == AM_BIDIR) || (amode == AM_STROBED && a_in);
  assign a_out_hs  = (amode == AM_BIDIR) || (amode == AM_STROBED && !a_in);
  assign b_capture = b_strobed && b_in;
  assign b_out_hs  = b_strobed && !b_in;
  assign sr_sel    = wdata_i[SR_SEL_HI:SR_SEL_LO];

  assign mode_wr = wr_en_i && addr_i == ADDR_CTRL && wdata_i[CW_MODE_SET];
  assign rd_a    = rd_en_i && addr_i == ADDR_PORT_A;
  assign rd_b    = rd_en_i && addr_i == ADDR_PORT_B;

  ////////////////////////////////////////////////////////////////////////////
  // Strobed input latches
  // Latched strobed inputs
  ppp_strobe_in u_stb_a (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .enable_i   (a_capture),
    .strobe_n_i (port_c_in_i[PC_STB_A]),
    .data_i     (port_a_in_i),
    .clear_i    (mode_wr || (rd_a && a_capture)),
    .data_o     (cap_a),
    .full_o     (input_full_a)
  );

  ppp_strobe_in u_stb_b (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .enable_i   (b_capture),
    .strobe_n_i (port_c_in_i[PC_STB_B]),
    .data_i     (port_b_in_i),
    .clear_i    (mode_wr || (rd_b && b_capture)),
    .data_o     (cap_b),
    .full_o     (input_full_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests
  // Request is enable and full
  // Output side raises its request once the peripheral empties the buffer
  assign irq_request_a = (a_capture && cur_ff.irq_enable_a && input_full_a)
                       | (a_out_hs && cur_ff.irq_enable_a_out && cur_ff.obf_n_a);
  assign irq_request_b = cur_ff.irq_enable_b
                       && ((b_capture && input_full_b) || (b_out_hs && cur_ff.obf_n_b));

  ////////////////////////////////////////////////////////////////////////////
  // Handshake line roles and status word
  always_comb begin
    hs_own = BYTE_RST;
    hs_val = BYTE_RST;
    hs_in  = BYTE_RST;
    // General lines read live when input, latch when output
    for (int i = 0; i < 8; i++) begin
      c_status[i] = ppp_c_is_in(cur_ff.ctrl, i) ? port_c_in_i[i] : cur_ff.c_lat[i];
    end
    if (a_capture) begin
      hs_own[PC_FULL_A]   = 1'b1;
      hs_val[PC_FULL_A]   = input_full_a;
      hs_in[PC_STB_A]     = 1'b1;
      c_status[PC_FULL_A] = input_full_a;
      c_status[PC_STB_A]  = cur_ff.irq_enable_a;
    end
    if (a_out_hs) begin
      hs_own[PC_OBF_A]    = 1'b1;
      hs_val[PC_OBF_A]    = cur_ff.obf_n_a;
      hs_in[PC_ACK_A]     = 1'b1;
      c_status[PC_OBF_A]  = cur_ff.obf_n_a;
      c_status[PC_ACK_A]  = cur_ff.irq_enable_a_out;
    end
    if (amode != AM_BASIC) begin
      hs_own[PC_INTR_A]   = 1'b1;
      hs_val[PC_INTR_A]   = irq_request_a;
      c_status[PC_INTR_A] = irq_request_a;
    end
    // Group B uses lower lines 0 to 2; line 3 stays with group A
    if (b_strobed) begin
      hs_own[PC_INTR_B]   = 1'b1;
      hs_val[PC_INTR_B]   = irq_request_b;
      hs_own[PC_FULL_B]   = 1'b1;
      hs_val[PC_FULL_B]   = b_in ? input_full_b : cur_ff.obf_n_b;
      hs_in[PC_STB_B]     = 1'b1;
      c_status[PC_INTR_B] = irq_request_b;
      c_status[PC_FULL_B] = hs_val[PC_FULL_B];
      c_status[PC_STB_B]  = cur_ff.irq_enable_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, reads and port drive
  always_comb begin
    nxt_cur = cur_ff;
    // Peripheral acknowledge empties the output buffers
    if (a_out_hs && !port_c_in_i[PC_ACK_A]) begin
      nxt_cur.obf_n_a = 1'b1;
    end
    if (b_out_hs && !port_c_in_i[PC_STB_B]) begin
      nxt_cur.obf_n_b = 1'b1;
    end
    if (wr_en_i) begin
      case (addr_i)
        ADDR_PORT_A: begin
          nxt_cur.a_lat = wdata_i;
          if (a_out_hs) begin
            nxt_cur.obf_n_a = 1'b0;
          end
        end
        ADDR_PORT_B: begin
          nxt_cur.b_lat = wdata_i;
          if (b_out_hs) begin
            nxt_cur.obf_n_b = 1'b0;
          end
        end
        ADDR_PORT_C: begin
          nxt_cur.c_lat = wdata_i;
        end
        ADDR_CTRL: begin
          if (wdata_i[CW_MODE_SET]) begin
            // New mode starts with clean latches and handshakes
            nxt_cur.ctrl             = wdata_i;
            nxt_cur.a_lat            = BYTE_RST;
            nxt_cur.b_lat            = BYTE_RST;
            nxt_cur.c_lat            = BYTE_RST;
            nxt_cur.irq_enable_a     = 1'b0;
            nxt_cur.irq_enable_a_out = 1'b0;
            nxt_cur.irq_enable_b     = 1'b0;
            nxt_cur.obf_n_a          = 1'b1;
            nxt_cur.obf_n_b          = 1'b1;
          end else begin
            nxt_cur.c_lat[sr_sel] = wdata_i[SR_VAL];
            if (int'(sr_sel) == PC_STB_A) begin
              nxt_cur.irq_enable_a = wdata_i[SR_VAL];
            end
            if (int'(sr_sel) == PC_ACK_A) begin
              nxt_cur.irq_enable_a_out = wdata_i[SR_VAL];
            end
            if (int'(sr_sel) == PC_STB_B) begin
              nxt_cur.irq_enable_b = wdata_i[SR_VAL];
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Read data register
    if (rd_en_i) begin
      case (addr_i)
        ADDR_PORT_A: begin
          if (a_capture) begin
            nxt_cur.rdata = cap_a;
          end else if (amode == AM_BASIC && a_in) begin
            nxt_cur.rdata = port_a_in_i;
          end else begin
            nxt_cur.rdata = cur_ff.a_lat;
          end
        end
        ADDR_PORT_B: begin
          if (b_capture) begin
            nxt_cur.rdata = cap_b;
          end else if (!b_strobed && b_in) begin
            nxt_cur.rdata = port_b_in_i;
          end else begin
            nxt_cur.rdata = cur_ff.b_lat;
          end
        end
        ADDR_PORT_C: begin
          nxt_cur.rdata = c_status;
        end
        // Control word is write only
        default: begin
          nxt_cur.rdata = BYTE_RST;
        end
      endcase
    end
    // Port directions
    // Bidirectional port drives only while the peripheral acknowledges
    case (amode)
      AM_BIDIR: nxt_cur.a_oe = {8{!port_c_in_i[PC_ACK_A]}};
      default:  nxt_cur.a_oe = {8{!a_in}};
    endcase
    nxt_cur.b_oe = {8{!b_in}};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset selects mode 0 with all ports input
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_ff <= '{ctrl: CTRL_RST, a_lat: BYTE_RST, b_lat: BYTE_RST, c_lat: BYTE_RST,
                  irq_enable_a: 1'b0, irq_enable_a_out: 1'b0, irq_enable_b: 1'b0,
                  obf_n_a: 1'b1, obf_n_b: 1'b1, rdata: BYTE_RST,
                  a_oe: BYTE_RST, b_oe: BYTE_RST};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port C pin drivers
  // Handshake on port C
  ppp_portc_pins u_portc (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ctrl_i    (cur_ff.ctrl),
    .latch_i   (cur_ff.c_lat),
    .hs_own_i  (hs_own),
    .hs_val_i  (hs_val),
    .hs_in_i   (hs_in),
    .pin_out_o (port_c_out_o),
    .pin_oe_o  (port_c_oe_o)
  );

  assign rdata_o      = cur_ff.rdata;
  assign port_a_out_o = cur_ff.a_lat;
  assign port_a_oe_o  = cur_ff.a_oe;
  assign port_b_out_o = cur_ff.b_lat;
  assign port_b_oe_o  = cur_ff.b_oe;

endmodule // ppp_top

// ---- bench/ppp_sva.sv ----
// Checker of host register and pin behaviour
`timescale 1ns/1ps
module ppp_sva (
  input logic       clock_i,      // Clock
  input logic       rst_n_i,      // Reset, low
  input logic [1:0] addr_i,       // Offset
  input logic       wr_en_i,      // Write
  input logic       rd_en_i,      // Read
  input logic [7:0] wdata_i,      // Write data
  input logic [7:0] rdata_o,      // Read data
  input logic [7:0] port_a_in_i,  // A pins
  input logic [7:0] port_a_out_o, // A drive
  input logic [7:0] port_a_oe_o,  // A enable
  input logic [7:0] port_b_oe_o,  // B enable
  input logic [7:0] port_c_in_i,  // C pins
  input logic [7:0] port_c_out_o, // C drive
  input logic [7:0] port_c_oe_o   // C enable
);
  logic [7:0] cw_ff;  // Control mirror
  logic       ena_ff; // A enable mirror
  wire        cw_wr  = wr_en_i && addr_i == 2'h3; // Control write
  wire        base_a = cw_ff[6:5] == 2'h0;        // A basic
  wire        stb_a  = cw_ff[6:4] == 3'h3;        // A strobed input
  // Mirror mode; a mode write also drops the enable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cw_ff  <= 8'h9b;
      ena_ff <= 1'b0;
    end else if (cw_wr && wdata_i[7]) begin
      cw_ff  <= wdata_i;
      ena_ff <= 1'b0;
    end else if (cw_wr && wdata_i[3:1] == 3'h4) begin
      ena_ff <= wdata_i[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_ctrl_noread: assert property (rd_en_i && addr_i == 2'h3 |=> rdata_o == 8'h00)
    else $error("control read not zero");
  // Enables are registered from the registered control word: two edges after the write
  a_dir_ab: assert property (cw_wr && wdata_i[7:5] == 3'h4 && !wdata_i[2] |=> ##1
    port_a_oe_o == {8{!$past(wdata_i[4], 2)}} && port_b_oe_o == {8{!$past(wdata_i[1], 2)}})
    else $error("port A or B direction wrong");
  a_dir_c: assert property (cw_wr && wdata_i[7:5] == 3'h4 && !wdata_i[2] ##1 !cw_wr |=>
    port_c_oe_o == {{4{!$past(wdata_i[3], 2)}}, {4{!$past(wdata_i[0], 2)}}})
    else $error("port C nibble direction wrong");
  a_latch_a: assert property (base_a && !cw_ff[4] && wr_en_i && addr_i == 2'h0 |=>
    port_a_out_o == $past(wdata_i))
    else $error("port A drive not written");
  a_live_a: assert property (base_a && cw_ff[4] && rd_en_i && addr_i == 2'h0 |=>
    rdata_o == $past(port_a_in_i))
    else $error("port A read not live");
  a_full_pin: assert property (stb_a && !cw_wr && $fell(port_c_in_i[4]) |->
    ##2 port_c_out_o[5])
    else $error("input full not raised");
  a_read_clear: assert property (stb_a && rd_en_i && addr_i == 2'h0 &&
    !$fell(port_c_in_i[4]) |-> ##2 !port_c_out_o[5])
    else $error("input full not cleared");
  a_status_a: assert property (stb_a && rd_en_i && addr_i == 2'h2 |=>
    rdata_o[4] == $past(ena_ff) && rdata_o[3] == (rdata_o[5] && rdata_o[4]))
    else $error("status enable or request wrong");
endmodule // ppp_sva

bind ppp_top ppp_sva ppp_sva_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .port_a_in_i(port_a_in_i),
  .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o), .port_b_oe_o(port_b_oe_o),
  .port_c_in_i(port_c_in_i), .port_c_out_o(port_c_out_o), .port_c_oe_o(port_c_oe_o)
);

// ---- bench/ppp_periph.sv ----
// Peripheral model on the port pins: levels and strobes
`timescale 1ns/1ps
module ppp_periph (
  input  logic       clock_i, // Clock
  input  logic [7:0] a_out_i, // A drive
  input  logic [7:0] a_oe_i,  // A enable
  input  logic [7:0] b_out_i, // B drive
  input  logic [7:0] b_oe_i,  // B enable
  input  logic [7:0] c_out_i, // C drive
  input  logic [7:0] c_oe_i,  // C enable
  output logic [7:0] a_pin_o, // A wire
  output logic [7:0] b_pin_o, // B wire
  output logic [7:0] c_pin_o  // C wire
);
  logic [7:0] a_ff = 8'h00; // Own drive A
  logic [7:0] b_ff = 8'h00; // Own drive B
  logic [7:0] c_ff = 8'hff; // Own drive C, strobes idle high
  // Device drive wins on enabled bits
  assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ff);
  assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ff);
  assign c_pin_o = (c_oe_i & c_out_i) | (~c_oe_i & c_ff);
  // General levels, changed just after an edge
  task automatic set_pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clock_i);
    a_ff <= a;
    b_ff <= b;
    c_ff <= c;
  endtask
  // data steady around one low strobe
  task automatic strobe(input logic sel_b, input logic [7:0] d);
    int k;
    k = sel_b ? 2 : 4;
    @(posedge clock_i);
    a_ff <= sel_b ? a_ff : d;
    b_ff <= sel_b ? d : b_ff;
    @(posedge clock_i);
    c_ff[k] <= 1'b0;
    repeat (2) @(posedge clock_i);
    c_ff[k] <= 1'b1;
    @(posedge clock_i);
    // Hold over: stale data shows inverted
    a_ff <= sel_b ? a_ff : ~d;
    b_ff <= sel_b ? ~d : b_ff;
  endtask
endmodule // ppp_periph

// ---- bench/tb.sv ----
// Self-checking bench for the programmable parallel port
`timescale 1ns/1ps
module tb;
  import ppp_pkg::*;
  logic       clock_i;                 // 125 MHz clock
  logic       rst_n_i;                 // Reset, low
  logic       wr_en_i;                 // Write strobe
  logic       rd_en_i;                 // Read strobe
  logic [1:0] addr_i;                  // Offset
  logic [7:0] wdata_i;                 // Write data
  logic [7:0] rdata_o;                 // Read data
  logic [7:0] a_pin, b_pin, c_pin;     // Wire levels
  logic [7:0] a_out, a_oe, b_out, b_oe; // Device drive
  logic [7:0] c_out, c_oe;             // Device drive C
  logic [7:0] cw, d, c;                // Scenario values
  int         err_total;               // Mismatches
  int         comparisons;             // Checks made
  ppp_top ppp_top_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .port_a_in_i(a_pin), .port_a_out_o(a_out), .port_a_oe_o(a_oe),
    .port_b_in_i(b_pin), .port_b_out_o(b_out), .port_b_oe_o(b_oe),
    .port_c_in_i(c_pin), .port_c_out_o(c_out), .port_c_oe_o(c_oe)
  );
  ppp_periph ppp_periph_i (
    .clock_i(clock_i), .a_out_i(a_out), .a_oe_i(a_oe), .b_out_i(b_out), .b_oe_i(b_oe),
    .c_out_i(c_out), .c_oe_i(c_oe), .a_pin_o(a_pin), .b_pin_o(b_pin), .c_pin_o(c_pin)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One write; the next call leaves an idle edge first
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
  endtask
  // One read; data stands just after the taking edge
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask
  // Let registered pin stages catch up
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  // Counts, verdict, end of run
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the roughly 410 cycles needed
  initial begin
    repeat (8000) @(posedge clock_i);
    err_total++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, wr_en_i, rd_en_i, addr_i, wdata_i} = '0;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    check(a_oe | b_oe | c_oe, 8'h00);
    ppp_periph_i.set_pins(8'h5c, 8'ha3, 8'h96);
    rd(ADDR_PORT_A, 8'h5c);
    rd(ADDR_CTRL, 8'h00);
    // Every basic direction set, with data through each port
    for (int i = 0; i < 16; i++) begin
      cw = {3'h4, i[3], i[2], 1'b0, i[1], i[0]};
      d = {4'h3, i[3:0]};
      wr(ADDR_CTRL, cw);
      wr(ADDR_PORT_A, d);
      wr(ADDR_PORT_B, ~d);
      wr(ADDR_PORT_C, d ^ 8'h5a);
      settle();
      c = d ^ 8'h5a;
      check(a_oe, {8{~cw[4]}});
      check(b_oe, {8{~cw[1]}});
      check(c_oe, {{4{~cw[3]}}, {4{~cw[0]}}});
      // Latches take the write even while the port is an input
      check(a_out, d);
      check(b_out, ~d);
      check(c_out, c);
      rd(ADDR_PORT_A, cw[4] ? 8'h5c : d);
      rd(ADDR_PORT_B, cw[1] ? 8'ha3 : ~d);
      rd(ADDR_PORT_C, {cw[3] ? 4'h9 : c[7:4], cw[0] ? 4'h6 : c[3:0]});
    end
    // Set each port C bit, then clear each
    wr(ADDR_CTRL, 8'h80);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CTRL, {4'h0, i[2:0], ~i[3]});
      settle();
      c = (i < 8) ? (8'hff >> (7 - i)) : (8'hff << (i - 7));
      check(c_out, c);
    end
    // Strobed input on port A
    ppp_periph_i.set_pins(8'h00, 8'h00, 8'hd4);
    wr(ADDR_CTRL, 8'hb0);
    // Lines 6 and 7 are outputs here, so only latch writes raise them, here set/reset words
    wr(ADDR_CTRL, 8'h0d);
    wr(ADDR_CTRL, 8'h0f);
    rd(ADDR_PORT_C, 8'hc0);
    ppp_periph_i.strobe(1'b0, 8'h6e);
    settle();
    check({7'h0, c_out[5]}, 8'h01);
    rd(ADDR_PORT_C, 8'he0);
    wr(ADDR_CTRL, 8'h09);
    rd(ADDR_PORT_C, 8'hf8);
    rd(ADDR_PORT_A, 8'h6e);
    rd(ADDR_PORT_C, 8'hd0);
    // Strobed input on port B
    wr(ADDR_CTRL, 8'h86);
    wr(ADDR_CTRL, 8'h05);
    ppp_periph_i.strobe(1'b1, 8'h93);
    settle();
    rd(ADDR_PORT_C, 8'h07);
    rd(ADDR_PORT_B, 8'h93);
    rd(ADDR_PORT_C, 8'h04);
    stop_test();
  end
endmodule // tb
